/* hw/genset_modbus_pkg.sv */
// Constants, register offsets and carrier types of the generator-set
// Modbus register bank. Assumes the Modbus TCP framing engine hands
// over one 16-bit register access at a time.
package genset_modbus_pkg;

  // Register addresses; a 32-bit value also takes the next register
  localparam logic [15:0] KEY_PRESS_SIMULATION_ADDR = 16'h2001;
  localparam logic [15:0] UTILITY_L1_VOLTAGE_ADDR = 16'h2800;
  localparam logic [15:0] UTILITY_L2_VOLTAGE_ADDR = 16'h2802;
  localparam logic [15:0] UTILITY_L3_VOLTAGE_ADDR = 16'h2804;
  localparam logic [15:0] GENERATOR_L1_VOLTAGE_ADDR = 16'h2806;
  localparam logic [15:0] GENERATOR_L2_VOLTAGE_ADDR = 16'h2808;
  localparam logic [15:0] GENERATOR_L3_VOLTAGE_ADDR = 16'h280a;
  localparam logic [15:0] UTILITY_L1L2_VOLTAGE_ADDR = 16'h280c;
  localparam logic [15:0] UTILITY_L2L3_VOLTAGE_ADDR = 16'h280e;
  localparam logic [15:0] UTILITY_L3L1_VOLTAGE_ADDR = 16'h2810;
  localparam logic [15:0] GENERATOR_L1L2_VOLTAGE_ADDR = 16'h2812;
  localparam logic [15:0] GENERATOR_L2L3_VOLTAGE_ADDR = 16'h2814;
  localparam logic [15:0] GENERATOR_L3L1_VOLTAGE_ADDR = 16'h2816;
  localparam logic [15:0] UTILITY_L1_CURRENT_ADDR = 16'h2818;
  localparam logic [15:0] UTILITY_L2_CURRENT_ADDR = 16'h281a;
  localparam logic [15:0] UTILITY_L3_CURRENT_ADDR = 16'h281c;
  localparam logic [15:0] GENERATOR_L1_CURRENT_ADDR = 16'h281e;
  localparam logic [15:0] GENERATOR_L2_CURRENT_ADDR = 16'h2820;
  localparam logic [15:0] GENERATOR_L3_CURRENT_ADDR = 16'h2822;
  localparam logic [15:0] UTILITY_NEUTRAL_CURRENT_ADDR = 16'h2824;
  localparam logic [15:0] GENERATOR_NEUTRAL_CURRENT_ADDR = 16'h2826;
  localparam logic [15:0] UTILITY_ACTIVE_POWER_ADDR = 16'h2834;
  localparam logic [15:0] GENERATOR_ACTIVE_POWER_ADDR = 16'h2836;
  localparam logic [15:0] UTILITY_REACTIVE_POWER_ADDR = 16'h2844;
  localparam logic [15:0] GENERATOR_REACTIVE_POWER_ADDR = 16'h2846;
  localparam logic [15:0] UTILITY_APPARENT_POWER_ADDR = 16'h2854;
  localparam logic [15:0] GENERATOR_APPARENT_POWER_ADDR = 16'h2856;
  localparam logic [15:0] UTILITY_POWER_FACTOR_ADDR = 16'h285e;
  localparam logic [15:0] GENERATOR_POWER_FACTOR_ADDR = 16'h285f;
  localparam logic [15:0] UTILITY_FREQUENCY_ADDR = 16'h2862;
  localparam logic [15:0] GENERATOR_FREQUENCY_ADDR = 16'h2863;
  localparam logic [15:0] STARTER_BATTERY_VOLTAGE_ADDR = 16'h2865;
  localparam logic [15:0] LUBE_PRESSURE_ADDR = 16'h2879;
  localparam logic [15:0] COOLANT_TEMPERATURE_ADDR = 16'h287a;
  localparam logic [15:0] TANK_LEVEL_PERCENT_ADDR = 16'h287b;
  localparam logic [15:0] LUBE_TEMPERATURE_ADDR = 16'h287c;
  localparam logic [15:0] ENCLOSURE_TEMPERATURE_ADDR = 16'h287d;
  localparam logic [15:0] OUTSIDE_AIR_TEMPERATURE_ADDR = 16'h287e;
  localparam logic [15:0] SHAFT_SPEED_ADDR = 16'h2888;

  // Index i of the measurement carrier belongs to address entry i
  localparam int WIDE_COUNT = 26;
  localparam int NARROW_COUNT = 12;
  localparam logic [15:0] WIDE_ADDR [WIDE_COUNT] = '{
    UTILITY_L1_VOLTAGE_ADDR, UTILITY_L2_VOLTAGE_ADDR,
    UTILITY_L3_VOLTAGE_ADDR, GENERATOR_L1_VOLTAGE_ADDR,
    GENERATOR_L2_VOLTAGE_ADDR, GENERATOR_L3_VOLTAGE_ADDR,
    UTILITY_L1L2_VOLTAGE_ADDR, UTILITY_L2L3_VOLTAGE_ADDR,
    UTILITY_L3L1_VOLTAGE_ADDR, GENERATOR_L1L2_VOLTAGE_ADDR,
    GENERATOR_L2L3_VOLTAGE_ADDR, GENERATOR_L3L1_VOLTAGE_ADDR,
    UTILITY_L1_CURRENT_ADDR, UTILITY_L2_CURRENT_ADDR,
    UTILITY_L3_CURRENT_ADDR, GENERATOR_L1_CURRENT_ADDR,
    GENERATOR_L2_CURRENT_ADDR, GENERATOR_L3_CURRENT_ADDR,
    UTILITY_NEUTRAL_CURRENT_ADDR, GENERATOR_NEUTRAL_CURRENT_ADDR,
    UTILITY_ACTIVE_POWER_ADDR, GENERATOR_ACTIVE_POWER_ADDR,
    UTILITY_REACTIVE_POWER_ADDR, GENERATOR_REACTIVE_POWER_ADDR,
    UTILITY_APPARENT_POWER_ADDR, GENERATOR_APPARENT_POWER_ADDR};
  localparam logic [15:0] NARROW_ADDR [NARROW_COUNT] = '{
    UTILITY_POWER_FACTOR_ADDR, GENERATOR_POWER_FACTOR_ADDR,
    UTILITY_FREQUENCY_ADDR, GENERATOR_FREQUENCY_ADDR,
    STARTER_BATTERY_VOLTAGE_ADDR, LUBE_PRESSURE_ADDR,
    COOLANT_TEMPERATURE_ADDR, TANK_LEVEL_PERCENT_ADDR,
    LUBE_TEMPERATURE_ADDR, ENCLOSURE_TEMPERATURE_ADDR,
    OUTSIDE_AIR_TEMPERATURE_ADDR, SHAFT_SPEED_ADDR};

  // Key press simulation bits: stop 0, test 3, run 4, breaker 5,
  // menu forward 7, menu back 8, up 9, down 10
  localparam logic [15:0] KEY_FUNCTION_MASK = 16'h07b9;
  localparam int KEY_LONG_BIT = 14;
  localparam int KEY_VERY_LONG_BIT = 15;
  localparam int KEY_GENERATOR_BREAKER_BUTTON_BIT = 5;

  // Network setting limits and reset values
  localparam logic [7:0] SLAVE_ADDRESS_MIN = 8'h01;
  localparam logic [7:0] SLAVE_ADDRESS_MAX = 8'hf0;
  localparam logic [7:0] SLAVE_ADDRESS_DEFAULT = 8'h01;
  localparam logic [15:0] TCP_PORT_RESET = 16'h01f6;
  localparam logic [31:0] FIRST_MASK_EXPECTED = 32'hffffff00;
  localparam logic [31:0] AUTO_ADDRESS_IP = 32'h00000000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Modbus exception codes in the answer
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;

  typedef struct packed {
    logic [7:0] slave_address;
    logic ethernet_enable;
    logic [15:0] tcp_port;
    logic [31:0] ip_mask_1;
    logic [31:0] ip_mask_2;
    logic [31:0] ip_mask_3;
    logic [31:0] network_ip;
    logic [31:0] gateway_ip;
    logic [31:0] subnet_mask;
  } net_settings_t;

  typedef struct packed {
    logic port_up;
    logic auto_address;
    logic first_mask_ok;
    logic [7:0] slave_address;
    logic [15:0] served_port;
    logic [31:0] claimed_ip;
    logic [31:0] gateway_ip;
    logic [31:0] subnet_mask;
  } net_status_t;

  typedef struct packed {
    logic [WIDE_COUNT-1:0][31:0] wide;
    logic [NARROW_COUNT-1:0][15:0] narrow;
  } meas_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] unit_id;
    logic [15:0] tcp_port;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] exception;
    logic [15:0] rdata;
  } reg_resp_t;

endpackage

/* hw/genset_modbus_register_map.sv */
// Modbus TCP register bank of the generator-set controller: network
// setting checks, register decode, measurement read-out and key press
// simulation. Assumes settings, measurements and register requests all
// come from logic on ref_clk, one register access per request.
//
// Overview of operation
// - Slave address 1..240, default 1 otherwise
// - Ethernet port works only when enable is 1
// - Serve Modbus on any configured TCP port
// - IP 0.0.0.0 means automatic address, else claimed
// - 16-bit value in one register, bit0 LSB
// - 32-bit value: high word first, low next
// - Bit arrays span registers, LSB first upward
// - Key simulation bits press front-panel keys
// - Bit 14 long press, bit 15 very long
// - Voltages, currents, powers: read-only 32-bit tenths
// - Power factor, frequency, battery: read-only 16-bit
// - Engine sensors read-only 16-bit, speed unscaled
`timescale 1ns/10ps
`default_nettype none

module genset_modbus_register_map (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Stored network settings
  input wire genset_modbus_pkg::net_settings_t settings,
  // Live measurements, already scaled
  input wire genset_modbus_pkg::meas_t meas,
  // One register access from the Modbus TCP framing engine
  input wire genset_modbus_pkg::reg_req_t req,
  output var genset_modbus_pkg::reg_resp_t resp,
  // Effective network state
  output var genset_modbus_pkg::net_status_t net_status,
  // Simulated key presses, one-cycle pulse
  output logic [15:0] key_press
);
  import genset_modbus_pkg::*;

  // Result of a wide lookup: {hit, low half, index}
  function automatic logic [6:0] decode_wide(input logic [15:0] a);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < WIDE_COUNT; i++) begin
      if (a == WIDE_ADDR[i]) begin
        r = {2'b10, 5'(i)};
      end else if (a == WIDE_ADDR[i] + 16'h0001) begin
        r = {2'b11, 5'(i)};
      end
    end
    return r;
  endfunction

  // Result of a narrow lookup: {hit, index}
  function automatic logic [4:0] decode_narrow(input logic [15:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NARROW_COUNT; i++) begin
      if (a == NARROW_ADDR[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic slave_in_range(input logic [7:0] a);
    return (a >= SLAVE_ADDRESS_MIN) && (a <= SLAVE_ADDRESS_MAX);
  endfunction

  net_status_t status_reg, status_next;
  reg_resp_t resp_reg, resp_next;
  logic [15:0] key_reg, key_next;

  logic accepted;
  logic [6:0] wide_hit;
  logic [4:0] narrow_hit;
  logic [31:0] wide_word;

  // Network state follows the stored settings
  always_comb begin
    status_next = status_reg;
    if (slave_in_range(settings.slave_address)) begin
      status_next.slave_address = settings.slave_address;
    end else begin
      status_next.slave_address = SLAVE_ADDRESS_DEFAULT;
    end
    status_next.port_up = settings.ethernet_enable;
    status_next.served_port = settings.tcp_port;
    // Only flagged: a wrong mask is the installer's to fix
    status_next.first_mask_ok =
      (settings.ip_mask_1 == FIRST_MASK_EXPECTED);
    status_next.auto_address =
      (settings.network_ip == AUTO_ADDRESS_IP);
    status_next.claimed_ip = settings.network_ip;
    status_next.gateway_ip = settings.gateway_ip;
    status_next.subnet_mask = settings.subnet_mask;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= '{port_up: 1'b0, auto_address: 1'b1,
                      first_mask_ok: 1'b0,
                      slave_address: SLAVE_ADDRESS_DEFAULT,
                      served_port: TCP_PORT_RESET,
                      claimed_ip: AUTO_ADDRESS_IP,
                      gateway_ip: AUTO_ADDRESS_IP,
                      subnet_mask: AUTO_ADDRESS_IP};
    end else begin
      status_reg <= status_next;
    end
  end

  // Requests that miss the port or unit id get no answer at all, as a
  // stopped port would; the framing engine times them out.
  assign accepted = req.valid && status_reg.port_up &&
                    (req.tcp_port == status_reg.served_port) &&
                    (req.unit_id == status_reg.slave_address);
  assign wide_hit = decode_wide(req.addr);
  assign narrow_hit = decode_narrow(req.addr);
  assign wide_word = meas.wide[wide_hit[4:0]];

  always_comb begin
    resp_next = '{valid: 1'b0, exception: EXC_NONE, rdata: DATA_RESET};
    key_next = 16'h0000;
    if (accepted) begin
      resp_next.valid = 1'b1;
      if (req.write) begin
        if (req.addr == KEY_PRESS_SIMULATION_ADDR) begin
          // Unassigned bits dropped; hold flags only ride on a key
          if ((req.wdata & KEY_FUNCTION_MASK) != 16'h0000) begin
            key_next = req.wdata & KEY_FUNCTION_MASK;
            key_next[KEY_LONG_BIT] = req.wdata[KEY_LONG_BIT];
            key_next[KEY_VERY_LONG_BIT] =
              req.wdata[KEY_VERY_LONG_BIT];
          end
        end else begin
          resp_next.exception = EXC_ILLEGAL_ADDRESS;
        end
      end else if (wide_hit[6]) begin
        if (wide_hit[5]) begin
          resp_next.rdata = wide_word[15:0];
        end else begin
          resp_next.rdata = wide_word[31:16];
        end
      end else if (narrow_hit[4]) begin
        // Bit 0 of the value lands on bit 0 of the register
        resp_next.rdata = meas.narrow[narrow_hit[3:0]];
      end else begin
        // Key register is write-only, the rest is unmapped
        resp_next.exception = EXC_ILLEGAL_ADDRESS;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      resp_reg <= '{valid: 1'b0, exception: EXC_NONE, rdata: DATA_RESET};
      key_reg <= 16'h0000;
    end else begin
      resp_reg <= resp_next;
      key_reg <= key_next;
    end
  end

  assign resp = resp_reg;
  assign net_status = status_reg;
  assign key_press = key_reg;

  // High once the previous edge was out of reset, so checks that look
  // one cycle back never see reset values
  logic past_ok;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      past_ok <= 1'b0;
    end else begin
      past_ok <= 1'b1;
    end
  end

  sequence seq_read_taken;
    accepted && !req.write;
  endsequence

  sequence seq_key_write;
    accepted && req.write && (req.addr == KEY_PRESS_SIMULATION_ADDR);
  endsequence

  AST_SLAVE_RANGE: assert property (
    @(posedge ref_clk) disable iff (reset)
    past_ok |-> slave_in_range(status_reg.slave_address))
    else $error("slave address outside 1..240");

  AST_SLAVE_DEFAULT: assert property (
    @(posedge ref_clk) disable iff (reset)
    !slave_in_range(settings.slave_address) |=>
      status_reg.slave_address == SLAVE_ADDRESS_DEFAULT)
    else $error("bad slave address not replaced by default");

  AST_PORT_DISABLED: assert property (
    @(posedge ref_clk) disable iff (reset)
    (req.valid && !status_reg.port_up) |=> !resp_reg.valid)
    else $error("answer given while port disabled");

  AST_PORT_MATCH: assert property (
    @(posedge ref_clk) disable iff (reset)
    resp_reg.valid |->
      $past(req.tcp_port) == $past(status_reg.served_port))
    else $error("answer on a port other than the served one");

  AST_AUTO_ADDRESS: assert property (
    @(posedge ref_clk) disable iff (reset)
    (settings.network_ip == AUTO_ADDRESS_IP) ##1 past_ok
      |-> status_reg.auto_address)
    else $error("zero IP did not select automatic address");

  AST_WIDE_ORDER: assert property (
    @(posedge ref_clk) disable iff (reset)
    (seq_read_taken and (wide_hit[6:5] == 2'b10)) |=>
      resp_reg.valid && resp_reg.rdata == $past(wide_word[31:16]))
    else $error("first register of a 32-bit value is not high half");

  AST_NARROW_READ: assert property (
    @(posedge ref_clk) disable iff (reset)
    (seq_read_taken and narrow_hit[4]) |=>
      resp_reg.exception == EXC_NONE &&
      resp_reg.rdata == $past(meas.narrow[narrow_hit[3:0]]))
    else $error("16-bit measurement read wrong");

  AST_KEY_PULSE: assert property (
    @(posedge ref_clk) disable iff (reset)
    seq_key_write ##1 (key_press != 16'h0000 && !(accepted &&
      req.write && req.addr == KEY_PRESS_SIMULATION_ADDR))
      |=> key_press == 16'h0000)
    else $error("key press lasted more than one cycle");

  AST_KEY_HOLD: assert property (
    @(posedge ref_clk) disable iff (reset)
    (seq_key_write and (req.wdata & KEY_FUNCTION_MASK) != 16'h0000) |=>
      key_press[KEY_VERY_LONG_BIT] == $past(req.wdata[KEY_VERY_LONG_BIT])
      && key_press[KEY_LONG_BIT] == $past(req.wdata[KEY_LONG_BIT]))
    else $error("long press flags not carried");

  AST_RO_WRITE: assert property (
    @(posedge ref_clk) disable iff (reset)
    (accepted && req.write && req.addr != KEY_PRESS_SIMULATION_ADDR) |=>
      resp_reg.exception == EXC_ILLEGAL_ADDRESS && key_press == 16'h0000)
    else $error("write to read-only register had an effect");

  AST_UNUSED_KEYS: assert property (
    @(posedge ref_clk) disable iff (reset)
    past_ok |-> (key_press & ~KEY_FUNCTION_MASK & 16'h3fff) == 16'h0000)
    else $error("unassigned key bit reached the panel");

  AST_SLAVE_FOLLOWS: assert property (
    @(posedge ref_clk) disable iff (reset)
    (past_ok && slave_in_range($past(settings.slave_address))) |->
      status_reg.slave_address == $past(settings.slave_address))
    else $error("valid slave address not taken over");

  AST_ANSWER_TAKEN: assert property (
    @(posedge ref_clk) disable iff (reset)
    accepted |=> resp_reg.valid)
    else $error("accepted request got no answer");

  AST_NO_STRAY_ANSWER: assert property (
    @(posedge ref_clk) disable iff (reset)
    !accepted |=> !resp_reg.valid)
    else $error("answer without an accepted request");

  AST_IDLE_RESP_ZERO: assert property (
    @(posedge ref_clk) disable iff (reset)
    !resp_reg.valid |->
      resp_reg.rdata == DATA_RESET && resp_reg.exception == EXC_NONE)
    else $error("answer fields not zero while idle");

  AST_PORT_FOLLOWS: assert property (
    @(posedge ref_clk) disable iff (reset)
    past_ok |-> status_reg.port_up == $past(settings.ethernet_enable))
    else $error("port state does not follow the enable setting");

  AST_SERVED_PORT: assert property (
    @(posedge ref_clk) disable iff (reset)
    past_ok |-> status_reg.served_port == $past(settings.tcp_port))
    else $error("served port does not follow the setting");

  AST_MASK_FLAG: assert property (
    @(posedge ref_clk) disable iff (reset)
    past_ok |-> status_reg.first_mask_ok ==
      ($past(settings.ip_mask_1) == FIRST_MASK_EXPECTED))
    else $error("first mask flag wrong");

  AST_CLAIMED_IP: assert property (
    @(posedge ref_clk) disable iff (reset)
    (past_ok && !status_reg.auto_address) |->
      status_reg.claimed_ip == $past(settings.network_ip) &&
      status_reg.claimed_ip != AUTO_ADDRESS_IP)
    else $error("configured IP not claimed");

  AST_WIDE_LOW: assert property (
    @(posedge ref_clk) disable iff (reset)
    (seq_read_taken and (wide_hit[6:5] == 2'b11)) |=>
      resp_reg.valid && resp_reg.rdata == $past(wide_word[15:0]))
    else $error("second register of a 32-bit value is not low half");

  AST_WIDE_OK: assert property (
    @(posedge ref_clk) disable iff (reset)
    (seq_read_taken and wide_hit[6]) |=> resp_reg.exception == EXC_NONE)
    else $error("32-bit measurement read refused");

  AST_SPEED_UNSCALED: assert property (
    @(posedge ref_clk) disable iff (reset)
    (seq_read_taken and (req.addr == SHAFT_SPEED_ADDR)) |=>
      resp_reg.rdata == $past(meas.narrow[NARROW_COUNT-1]))
    else $error("engine speed not passed through unscaled");

  AST_KEY_ANSWER: assert property (
    @(posedge ref_clk) disable iff (reset)
    seq_key_write |=> resp_reg.valid && resp_reg.exception == EXC_NONE)
    else $error("key write not answered");

  AST_KEY_EMPTY: assert property (
    @(posedge ref_clk) disable iff (reset)
    (seq_key_write and ((req.wdata & KEY_FUNCTION_MASK) == 16'h0000))
      |=> key_press == 16'h0000)
    else $error("key write without key bits had an effect");

  AST_KEY_SOURCE: assert property (
    @(posedge ref_clk) disable iff (reset)
    (key_press != 16'h0000) |->
      $past(accepted && req.write && req.addr == KEY_PRESS_SIMULATION_ADDR))
    else $error("key press without a key write");

  AST_WRITE_ONLY_KEY: assert property (
    @(posedge ref_clk) disable iff (reset)
    (seq_read_taken and (req.addr == KEY_PRESS_SIMULATION_ADDR)) |=>
      resp_reg.exception == EXC_ILLEGAL_ADDRESS &&
      resp_reg.rdata == DATA_RESET)
    else $error("write-only key register was readable");

  // Every key bit keeps its own position, lowest bit first
  for (genvar k = 0; k < 16; k++) begin : g_key_bit
    AST_KEY_BIT_ORDER: assert property (
      @(posedge ref_clk) disable iff (reset)
      (seq_key_write and ((req.wdata & KEY_FUNCTION_MASK) != 16'h0000))
        |=> key_press[k] == ($past(req.wdata[k]) &&
        (KEY_FUNCTION_MASK[k] || k >= KEY_LONG_BIT)))
      else $error("key bit moved to another position");
  end

endmodule // genset_modbus_register_map

`default_nettype wire

/* sim/modbus_client_model.sv */
// Modbus TCP client model: hands the register bank one register access
// at a time. Assumes the bank answers on the taking edge, read at the next falling edge.
`timescale 1ns/10ps
`default_nettype none

module modbus_client_model (
  // Clock
  input wire logic ref_clk,
  // Register port of the bank
  output var genset_modbus_pkg::reg_req_t req,
  input wire genset_modbus_pkg::reg_resp_t resp
);
  import genset_modbus_pkg::*;

  initial req = '0;

  // Released fields show the inverse so a stale value is never mistaken
  // for a held one
  task automatic access(input logic wr, input logic [7:0] unit,
      input logic [15:0] port, input logic [15:0] addr,
      input logic [15:0] wd, output reg_resp_t got);
    @(posedge ref_clk);
    req <= '{valid: 1'b1, write: wr, unit_id: unit, tcp_port: port,
             addr: addr, wdata: wd};
    @(posedge ref_clk);
    req <= '{valid: 1'b0, write: ~wr, unit_id: ~unit, tcp_port: ~port,
             addr: ~addr, wdata: ~wd};
    @(negedge ref_clk);
    got = resp;
  endtask
endmodule // modbus_client_model

`default_nettype wire

/* sim/test_genset_modbus_register_map.sv */
// Self-checking bench for the generator-set Modbus register bank.
// Assumes the client model drives every register request.
`timescale 1ns/10ps
`default_nettype none

module test_genset_modbus_register_map;
  import genset_modbus_pkg::*;

  logic ref_clk;
  logic reset;
  net_settings_t settings;
  net_settings_t s;
  meas_t meas;
  reg_req_t req;
  reg_resp_t resp;
  reg_resp_t got;
  net_status_t net_status;
  logic [15:0] key_press;
  logic [7:0] unit;
  logic [15:0] port;
  logic [7:0] sa_in [5] = '{8'h00, 8'h01, 8'hf0, 8'hf1, 8'hff};
  logic [7:0] sa_exp [5] = '{8'h01, 8'h01, 8'hf0, 8'h01, 8'h01};
  int key_bit [8] = '{0, 3, 4, 5, 7, 8, 9, 10};
  int errors;
  int cmp_count;
  int cycles;

  genset_modbus_register_map uut (.ref_clk(ref_clk), .reset(reset),
    .settings(settings), .meas(meas), .req(req), .resp(resp),
    .net_status(net_status), .key_press(key_press));
  modbus_client_model client (.ref_clk(ref_clk), .req(req), .resp(resp));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      $display("mismatch at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e,
      input string what);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic xfer(input logic wr, input logic [15:0] a,
      input logic [15:0] wd, input logic [7:0] exc, input logic [15:0] e);
    client.access(wr, unit, port, a, wd, got);
    check(got.valid, 1'b1, "answer");
    check(got.exception, exc, "exception");
    if (!wr)
      check(got.rdata, e, "read data");
  endtask

  task automatic quiet(input logic [7:0] u, input logic [15:0] p);
    client.access(1'b0, u, p, UTILITY_FREQUENCY_ADDR, 16'h0000, got);
    check(got.valid, 1'b0, "unexpected answer");
  endtask

  task automatic apply();
    @(posedge ref_clk);
    settings <= s;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  initial begin
    reset = 1'b1;
    s = '0;
    s.slave_address = 8'h07;
    s.ethernet_enable = 1'b1;
    s.tcp_port = 16'h04d2;
    s.ip_mask_1 = 32'hffffff00;
    s.network_ip = 32'h0a000005;
    s.gateway_ip = 32'h0a000001;
    s.subnet_mask = 32'hffffff00;
    settings = s;
    for (int i = 0; i < WIDE_COUNT; i++)
      meas.wide[i] = {16'h1000 + 16'(i), 16'hc000 + 16'(i)};
    for (int i = 0; i < NARROW_COUNT; i++)
      meas.narrow[i] = 16'h8001 + 16'(i << 4);
    unit = 8'h07;
    port = 16'h04d2;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check(net_status.served_port, 16'h04d2, "port");
    check(net_status.first_mask_ok, 1'b1, "mask");
    check(net_status.auto_address, 1'b0, "auto");
    check(net_status.claimed_ip, 32'h0a000005, "claimed ip");
    check(net_status.gateway_ip, 32'h0a000001, "gateway");
    check(net_status.subnet_mask, 32'hffffff00, "subnet");
    quiet(8'h07, TCP_PORT_RESET);
    for (int i = 0; i < WIDE_COUNT; i++) begin
      xfer(1'b0, WIDE_ADDR[i], 16'h0000, EXC_NONE, 16'h1000 + 16'(i));
      xfer(1'b0, WIDE_ADDR[i] + 16'h0001, 16'h0000, EXC_NONE,
           16'hc000 + 16'(i));
    end
    // Twelve narrow registers are mapped
    for (int i = 0; i < 12; i++)
      xfer(1'b0, NARROW_ADDR[i], 16'h0000, EXC_NONE,
           16'h8001 + 16'(i << 4));
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, KEY_PRESS_SIMULATION_ADDR,
           (16'h4000 << (i % 2)) | (16'h0001 << key_bit[i]), EXC_NONE,
           16'h0000);
      check(key_press, (16'h4000 << (i % 2)) | (16'h0001 << key_bit[i]),
            "key");
      @(negedge ref_clk);
      check(key_press, 16'h0000, "key release");
    end
    xfer(1'b1, KEY_PRESS_SIMULATION_ADDR, 16'h3846, EXC_NONE, 16'h0000);
    check(key_press, 16'h0000, "unused key bits");
    xfer(1'b1, UTILITY_L1_VOLTAGE_ADDR, 16'hdead, EXC_ILLEGAL_ADDRESS,
         16'h0000);
    check(key_press, 16'h0000, "ro write");
    xfer(1'b0, UTILITY_L1_VOLTAGE_ADDR, 16'h0000, EXC_NONE, 16'h1000);
    xfer(1'b0, KEY_PRESS_SIMULATION_ADDR, 16'h0000, EXC_ILLEGAL_ADDRESS,
         16'h0000);
    xfer(1'b0, 16'h2000, 16'h0000, EXC_ILLEGAL_ADDRESS, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      s.slave_address = sa_in[i];
      apply();
      check(net_status.slave_address, sa_exp[i], "slave address");
      unit = sa_exp[i];
      xfer(1'b0, UTILITY_FREQUENCY_ADDR, 16'h0000, EXC_NONE, 16'h8021);
      quiet(sa_exp[i] + 8'h01, port);
    end
    s.ethernet_enable = 1'b0;
    s.network_ip = AUTO_ADDRESS_IP;
    apply();
    check(net_status.port_up, 1'b0, "port down");
    check(net_status.auto_address, 1'b1, "auto");
    quiet(unit, port);
    s.ethernet_enable = 1'b1;
    s.tcp_port = TCP_PORT_RESET;
    apply();
    port = TCP_PORT_RESET;
    xfer(1'b0, SHAFT_SPEED_ADDR, 16'h0000, EXC_NONE, 16'h80b1);
    final_report();
  end
endmodule // test_genset_modbus_register_map

`default_nettype wire
